// ### common/vdrp_pkg.sv
// Constants, register map and types of the video decoder register port.
package vdrp_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned SYS_CLK_PERIOD_NS = 8;
  localparam int unsigned WR_DELAY_NS       = 64000;
  localparam int unsigned BUSY_W            = 16;
  localparam logic [1:0]  SEL_SETTLE        = 2'h2;

  // ****************************************************************
  // Serial slave addresses and framing
  // ****************************************************************
  localparam logic [7:0] WR_ADDR_SEL_LO = 8'hB8;
  localparam logic [7:0] RD_ADDR_SEL_LO = 8'hB9;
  localparam logic [7:0] WR_ADDR_SEL_HI = 8'hBA;
  localparam logic [7:0] RD_ADDR_SEL_HI = 8'hBB;
  localparam logic [7:0] NO_DELAY_BASE  = 8'h90;
  localparam logic [3:0] BYTE_LAST_BIT  = 4'h7;
  localparam logic [3:0] ACK_SLOT       = 4'h8;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned NUM_REGS  = 49;
  localparam logic [7:0]  LAST_REG  = 8'h30;
  localparam logic [7:0] INPUT_SOURCE_SELECT    = 8'h00;
  localparam logic [7:0] ANALOG_CHANNEL_CTRL    = 8'h01;
  localparam logic [7:0] OPERATION_MODE_CTRL    = 8'h02;
  localparam logic [7:0] MISC_CTRL              = 8'h03;
  localparam logic [7:0] AUTO_SWITCH_MASK       = 8'h04;
  localparam logic [7:0] COLOR_KILL_THRESHOLD   = 8'h06;
  localparam logic [7:0] LUMA_PROC_CTRL_A       = 8'h07;
  localparam logic [7:0] LUMA_PROC_CTRL_B       = 8'h08;
  localparam logic [7:0] BRIGHTNESS_LEVEL       = 8'h09;
  localparam logic [7:0] SATURATION_LEVEL       = 8'h0A;
  localparam logic [7:0] HUE_LEVEL              = 8'h0B;
  localparam logic [7:0] CONTRAST_LEVEL         = 8'h0C;
  localparam logic [7:0] OUTPUT_RATE_SELECT     = 8'h0D;
  localparam logic [7:0] LUMA_PROC_CTRL_C       = 8'h0E;
  localparam logic [7:0] SHARED_PIN_CONFIG      = 8'h0F;
  localparam logic [7:0] CROP_START_HI          = 8'h11;
  localparam logic [7:0] CROP_START_LO          = 8'h12;
  localparam logic [7:0] CROP_STOP_HI           = 8'h13;
  localparam logic [7:0] CROP_STOP_LO           = 8'h14;
  localparam logic [7:0] COLOR_LOCK_OUTPUT_CTRL = 8'h15;
  localparam logic [7:0] HSYNC_START_POS        = 8'h16;
  localparam logic [7:0] VBLANK_START_LINE      = 8'h18;
  localparam logic [7:0] VBLANK_STOP_LINE       = 8'h19;
  localparam logic [7:0] CHROMA_PROC_CTRL_A     = 8'h1A;
  localparam logic [7:0] CHROMA_PROC_CTRL_B     = 8'h1B;
  localparam logic [7:0] IRQ_CLEAR_B            = 8'h1C;
  localparam logic [7:0] IRQ_ENABLE_B           = 8'h1D;
  localparam logic [7:0] IRQ_CONFIG_B           = 8'h1E;
  localparam logic [7:0] VIDEO_STANDARD_SEL     = 8'h28;
  localparam logic [7:0] BLUE_DIFF_GAIN         = 8'h2C;
  localparam logic [7:0] RED_DIFF_GAIN          = 8'h2D;
  localparam logic [7:0] COPY_GUARD_ON_COUNT    = 8'h2E;
  localparam logic [7:0] COPY_GUARD_OFF_COUNT   = 8'h2F;
  localparam logic [7:0] EMBEDDED_SYNC_REV_SEL  = 8'h30;

  // Reset values; reserved and read-only slots hold zero.
  localparam logic [7:0] REG_RST [0:NUM_REGS-1] = '{
    ANALOG_CHANNEL_CTRL:    8'h15,
    MISC_CTRL:              8'h01,
    AUTO_SWITCH_MASK:       8'hFC,
    COLOR_KILL_THRESHOLD:   8'h10,
    LUMA_PROC_CTRL_A:       8'h60,
    BRIGHTNESS_LEVEL:       8'h80,
    SATURATION_LEVEL:       8'h80,
    CONTRAST_LEVEL:         8'h80,
    OUTPUT_RATE_SELECT:     8'h47,
    SHARED_PIN_CONFIG:      8'h08,
    COLOR_LOCK_OUTPUT_CTRL: 8'h01,
    HSYNC_START_POS:        8'h80,
    CHROMA_PROC_CTRL_A:     8'h0C,
    CHROMA_PROC_CTRL_B:     8'h14,
    COPY_GUARD_ON_COUNT:    8'h0F,
    COPY_GUARD_OFF_COUNT:   8'h01,
    default:                8'h00
  };
  // One bit per slot: writable slots, and slots that read back a value.
  localparam logic [NUM_REGS-1:0] REG_WR_MASK = 49'h1C1007F7EFFDF;
  localparam logic [NUM_REGS-1:0] REG_RD_MASK = 49'h1F1007F7EFFDF;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_DEVADDR = 5'h02,
    ST_SUBADDR = 5'h04,
    ST_WRDATA  = 5'h08,
    ST_RDDATA  = 5'h10
  } vdrp_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic sel;
    logic pdn_n;
    logic rst_n;
    logic tgl;
    logic bitv;
  } vdrp_pins_t;

endpackage : vdrp_pkg

// ### design/vdrp_top.sv
// Serial slave register port of the video decoder, with its control register file.
//
// Summary of operation
// - Read address B9 or BB by select.
// - Read address acked, then data MSB first.
// - Reads start at subaddress, then auto-increment.
// - On not-acknowledge, release data line.
// - Hold clock low while internally busy.
// - Writes below 90h delayed, above none.
// - Decode power-down and reset pin pair.
// - Registers reset to defaults; 2Ch, 2Dh read-only.
// - All parameters reached only through this port.
// - Write address B8 or BA by select.
// - Ack every write byte, store, then advance.
// - Sample address select pin once after power-up.
`timescale 1ns/1ns

module vdrp_top #(
  parameter int unsigned WR_DELAY_CYC =
    (vdrp_pkg::WR_DELAY_NS + vdrp_pkg::SYS_CLK_PERIOD_NS - 1) / vdrp_pkg::SYS_CLK_PERIOD_NS
) (
  // System clock and reset
  input  wire logic                                   sys_clk,
  input  wire logic                                   rst_b,
  // Serial link clock, the same wire as the clock pin
  input  wire logic                                   scl_link_clk,
  // Serial clock pin, open drain
  input  wire logic                                   scl_in,
  output logic                                        scl_out,
  output logic                                        scl_oe,
  // Serial data pin, open drain
  input  wire logic                                   sda_in,
  output logic                                        sda_out,
  output logic                                        sda_oe,
  // Strap and mode pins
  input  wire logic                                   slave_addr_select_pin,
  input  wire logic                                   power_down_pin_n,
  input  wire logic                                   hard_reset_pin_n,
  // Read-only gain factors from the chroma path
  input  wire logic [7:0]                             blue_diff_gain_in,
  input  wire logic [7:0]                             red_diff_gain_in,
  // Control state towards the decoder core
  output logic [vdrp_pkg::NUM_REGS-1:0][7:0]          ctrl_reg_image,
  output logic                                        dec_power_down,
  output logic                                        dec_in_reset,
  output logic                                        addr_select_latched
);

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef struct packed {
    logic rst_m;
    logic rst_s;
    logic tgl;
    logic bitv;
  } vdrp_link_t;

  typedef struct packed {
    vdrp_pkg::vdrp_pins_t                  s1;
    vdrp_pkg::vdrp_pins_t                  s2;
    logic                                  prev_scl;
    logic                                  prev_sda;
    logic                                  prev_tgl;
    logic [1:0]                            sel_wait;
    logic                                  sel_done;
    logic                                  sel;
    logic                                  dec_pd;
    logic                                  dec_rst;
    vdrp_pkg::vdrp_state_t                 state;
    logic [3:0]                            bitcnt;
    logic [7:0]                            shift;
    logic [7:0]                            ptr;
    logic [7:0]                            tx;
    logic                                  rw;
    logic                                  ack_due;
    logic                                  tx_act;
    logic                                  stretch_pend;
    logic [vdrp_pkg::BUSY_W-1:0]           busy;
    logic                                  sda_low;
    logic                                  scl_low;
    logic                                  pin_lvl;
    logic [vdrp_pkg::NUM_REGS-1:0][7:0]    regs;
  } vdrp_sys_t;

  vdrp_link_t lnk_ff;
  vdrp_link_t nxt_lnk;
  vdrp_sys_t  sys_ff;
  vdrp_sys_t  nxt_sys;

  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       bit_evt;
  logic [7:0] byte_c;
  logic [7:0] my_wr;
  logic [7:0] my_rd;
  logic       ptr_in_map;
  logic       wr_ok;
  logic [7:0] rd_data;

  // ****************************************************************
  // Link domain: capture each data bit on the rising serial clock
  // ****************************************************************
  // The link clock also pulses outside frames, yet this side does nothing but
  // sample; framing is decided in the system domain, which sees every edge.
  always_comb begin
    nxt_lnk       = lnk_ff;
    nxt_lnk.rst_m = rst_b;
    nxt_lnk.rst_s = lnk_ff.rst_m;
    if (!lnk_ff.rst_s) begin
      nxt_lnk.tgl  = 1'b0;
      nxt_lnk.bitv = 1'b0;
    end else begin
      nxt_lnk.tgl  = ~lnk_ff.tgl;
      nxt_lnk.bitv = sda_in;
    end
  end

  always_ff @(posedge scl_link_clk) begin
    lnk_ff <= nxt_lnk;
  end

  // ****************************************************************
  // Bus events and address decode
  // ****************************************************************
  assign scl_fall = sys_ff.prev_scl & ~sys_ff.s2.scl;
  assign start_c  = sys_ff.s2.scl & sys_ff.prev_scl & sys_ff.prev_sda & ~sys_ff.s2.sda;
  assign stop_c   = sys_ff.s2.scl & sys_ff.prev_scl & ~sys_ff.prev_sda & sys_ff.s2.sda;
  assign bit_evt  = (sys_ff.s2.tgl ^ sys_ff.prev_tgl) & (sys_ff.state != vdrp_pkg::ST_IDLE);
  assign byte_c   = {sys_ff.shift[6:0], sys_ff.s2.bitv};
  assign my_wr    = sys_ff.sel ? vdrp_pkg::WR_ADDR_SEL_HI : vdrp_pkg::WR_ADDR_SEL_LO;
  assign my_rd    = sys_ff.sel ? vdrp_pkg::RD_ADDR_SEL_HI : vdrp_pkg::RD_ADDR_SEL_LO;

  assign ptr_in_map = sys_ff.ptr <= vdrp_pkg::LAST_REG;
  // Reserved and read-only slots swallow writes so the map stays consistent.
  assign wr_ok      = ptr_in_map && vdrp_pkg::REG_WR_MASK[sys_ff.ptr[5:0]];

  assign rd_data = (sys_ff.ptr == vdrp_pkg::BLUE_DIFF_GAIN) ? blue_diff_gain_in :
                   (sys_ff.ptr == vdrp_pkg::RED_DIFF_GAIN)  ? red_diff_gain_in  :
                   (ptr_in_map && vdrp_pkg::REG_RD_MASK[sys_ff.ptr[5:0]]) ?
                   sys_ff.regs[sys_ff.ptr[5:0]] : 8'h00;

  // ****************************************************************
  // System domain: synchronisers, slave engine, register file
  // ****************************************************************
  always_comb begin
    nxt_sys    = sys_ff;
    nxt_sys.s1 = '{scl:   scl_in,
                   sda:   sda_in,
                   sel:   slave_addr_select_pin,
                   pdn_n: power_down_pin_n,
                   rst_n: hard_reset_pin_n,
                   tgl:   lnk_ff.tgl,
                   bitv:  lnk_ff.bitv};
    nxt_sys.s2       = sys_ff.s1;
    nxt_sys.prev_scl = sys_ff.s2.scl;
    nxt_sys.prev_sda = sys_ff.s2.sda;
    nxt_sys.prev_tgl = sys_ff.s2.tgl;

    nxt_sys.dec_pd  = ~sys_ff.s2.pdn_n & sys_ff.s2.rst_n;
    nxt_sys.dec_rst = ~sys_ff.s2.rst_n;

    // The strap is taken once the synchroniser holds real pin samples.
    if (!sys_ff.sel_done) begin
      if (sys_ff.sel_wait == vdrp_pkg::SEL_SETTLE) begin
        nxt_sys.sel      = sys_ff.s2.sel;
        nxt_sys.sel_done = 1'b1;
      end else begin
        nxt_sys.sel_wait = sys_ff.sel_wait + 2'h1;
      end
    end

    // Clock stretch countdown.
    if (sys_ff.busy != '0) begin
      nxt_sys.busy = sys_ff.busy - 1'b1;
    end else begin
      nxt_sys.scl_low = 1'b0;
    end

    // Data pin changes only while the clock is low.
    if (scl_fall) begin
      if (sys_ff.ack_due) begin
        nxt_sys.sda_low = 1'b1;
        nxt_sys.ack_due = 1'b0;
        if (sys_ff.stretch_pend) begin
          nxt_sys.busy         = vdrp_pkg::BUSY_W'(WR_DELAY_CYC);
          nxt_sys.scl_low      = 1'b1;
          nxt_sys.stretch_pend = 1'b0;
        end
      end else if (sys_ff.state == vdrp_pkg::ST_RDDATA && sys_ff.tx_act &&
                   sys_ff.bitcnt < vdrp_pkg::ACK_SLOT) begin
        nxt_sys.sda_low = ~sys_ff.tx[3'(vdrp_pkg::BYTE_LAST_BIT - sys_ff.bitcnt)];
      end else begin
        nxt_sys.sda_low = 1'b0;
      end
    end

    // Bit sampled on a rising clock edge.
    if (bit_evt) begin
      if (sys_ff.bitcnt != vdrp_pkg::ACK_SLOT) begin
        nxt_sys.shift  = byte_c;
        nxt_sys.bitcnt = sys_ff.bitcnt + 4'h1;
        if (sys_ff.bitcnt == vdrp_pkg::BYTE_LAST_BIT) begin
          unique case (sys_ff.state)
            vdrp_pkg::ST_IDLE: begin
              nxt_sys.ack_due = 1'b0;
            end
            vdrp_pkg::ST_DEVADDR: begin
              if (byte_c == my_wr || byte_c == my_rd) begin
                nxt_sys.ack_due = 1'b1;
                nxt_sys.rw      = (byte_c == my_rd);
              end else begin
                nxt_sys.state = vdrp_pkg::ST_IDLE;
              end
            end
            vdrp_pkg::ST_SUBADDR: begin
              nxt_sys.ptr     = byte_c;
              nxt_sys.ack_due = 1'b1;
            end
            vdrp_pkg::ST_WRDATA: begin
              if (wr_ok) begin
                nxt_sys.regs[sys_ff.ptr[5:0]] = byte_c;
              end
              nxt_sys.ptr          = sys_ff.ptr + 8'h01;
              nxt_sys.ack_due      = 1'b1;
              nxt_sys.stretch_pend = sys_ff.ptr < vdrp_pkg::NO_DELAY_BASE;
            end
            vdrp_pkg::ST_RDDATA: begin
              nxt_sys.ack_due = 1'b0;
            end
          endcase
        end
      end else begin
        // Acknowledge slot: the device's own ack, or the master's on reads.
        nxt_sys.bitcnt = 4'h0;
        unique case (sys_ff.state)
          vdrp_pkg::ST_IDLE: begin
            nxt_sys.tx_act = 1'b0;
          end
          vdrp_pkg::ST_DEVADDR: begin
            if (sys_ff.rw) begin
              nxt_sys.state  = vdrp_pkg::ST_RDDATA;
              nxt_sys.tx     = rd_data;
              nxt_sys.ptr    = sys_ff.ptr + 8'h01;
              nxt_sys.tx_act = 1'b1;
            end else begin
              nxt_sys.state = vdrp_pkg::ST_SUBADDR;
            end
          end
          vdrp_pkg::ST_SUBADDR: begin
            nxt_sys.state = vdrp_pkg::ST_WRDATA;
          end
          vdrp_pkg::ST_WRDATA: begin
            nxt_sys.state = vdrp_pkg::ST_WRDATA;
          end
          vdrp_pkg::ST_RDDATA: begin
            if (sys_ff.s2.bitv) begin
              nxt_sys.tx_act = 1'b0;
            end else if (sys_ff.tx_act) begin
              nxt_sys.tx  = rd_data;
              nxt_sys.ptr = sys_ff.ptr + 8'h01;
            end
          end
        endcase
      end
    end

    // Framing conditions win over any bit in flight.
    if (start_c || stop_c) begin
      nxt_sys.state        = start_c ? vdrp_pkg::ST_DEVADDR : vdrp_pkg::ST_IDLE;
      nxt_sys.bitcnt       = 4'h0;
      nxt_sys.ack_due      = 1'b0;
      nxt_sys.tx_act       = 1'b0;
      nxt_sys.sda_low      = 1'b0;
      nxt_sys.stretch_pend = 1'b0;
    end

    // Reset pin: the register file returns to defaults, the bus is let go.
    if (!sys_ff.s2.rst_n) begin
      nxt_sys.state        = vdrp_pkg::ST_IDLE;
      nxt_sys.bitcnt       = 4'h0;
      nxt_sys.ack_due      = 1'b0;
      nxt_sys.tx_act       = 1'b0;
      nxt_sys.stretch_pend = 1'b0;
      nxt_sys.busy         = '0;
      nxt_sys.sda_low      = 1'b0;
      nxt_sys.scl_low      = 1'b0;
      for (int i = 0; i < vdrp_pkg::NUM_REGS; i++) begin
        nxt_sys.regs[i] = vdrp_pkg::REG_RST[i];
      end
    end

    if (!rst_b) begin
      nxt_sys       = '0;
      nxt_sys.state = vdrp_pkg::ST_IDLE;
      for (int i = 0; i < vdrp_pkg::NUM_REGS; i++) begin
        nxt_sys.regs[i] = vdrp_pkg::REG_RST[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    sys_ff <= nxt_sys;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign scl_out             = sys_ff.pin_lvl;
  assign scl_oe              = sys_ff.scl_low;
  assign sda_out             = sys_ff.pin_lvl;
  assign sda_oe              = sys_ff.sda_low;
  assign ctrl_reg_image      = sys_ff.regs;
  assign dec_power_down      = sys_ff.dec_pd;
  assign dec_in_reset        = sys_ff.dec_rst;
  assign addr_select_latched = sys_ff.sel;

endmodule : vdrp_top

// ### bench/vdrp_assertions.sv
// Pin-level checks of the register port.
`timescale 1ns/1ns
module vdrp_checker #(
  parameter int unsigned WR_DELAY_CYC = 8000
) (
  // Clock and reset
  input wire logic                                  sys_clk,
  input wire logic                                  rst_b,
  // Open-drain pins
  input wire logic                                  scl_in,
  input wire logic                                  scl_out,
  input wire logic                                  scl_oe,
  input wire logic                                  sda_out,
  input wire logic                                  sda_oe,
  // Strap and mode pins
  input wire logic                                  slave_addr_select_pin,
  input wire logic                                  power_down_pin_n,
  input wire logic                                  hard_reset_pin_n,
  // Decoder side
  input wire logic [vdrp_pkg::NUM_REGS-1:0][7:0]    ctrl_reg_image,
  input wire logic                                  dec_power_down,
  input wire logic                                  dec_in_reset,
  input wire logic                                  addr_select_latched
);
  // ****************************************************************
  // Helper counters
  // ****************************************************************
  logic [3:0]  up_cnt_ff;
  int unsigned hold_cnt_ff;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      up_cnt_ff   <= 4'h0;
      hold_cnt_ff <= 0;
    end else begin
      up_cnt_ff   <= (up_cnt_ff == 4'hF) ? up_cnt_ff : up_cnt_ff + 4'h1;
      hold_cnt_ff <= scl_oe ? hold_cnt_ff + 1 : 0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_quiet_reset: assert property (disable iff (1'b0) !rst_b |=> !scl_oe && !sda_oe)
    else $error("pins driven in reset");
  a_pins_open: assert property (!scl_out && !sda_out)
    else $error("pin drives a high level");
  a_pd_decode: assert property ($stable({power_down_pin_n, hard_reset_pin_n})[*6]
    |-> dec_power_down == (!power_down_pin_n && hard_reset_pin_n))
    else $error("power-down decode wrong");
  a_rst_decode: assert property ($stable({power_down_pin_n, hard_reset_pin_n})[*6]
    |-> dec_in_reset == !hard_reset_pin_n)
    else $error("reset decode wrong");
  a_strap_kept: assert property (up_cnt_ff == 4'hF
    |-> addr_select_latched == slave_addr_select_pin)
    else $error("strap level not latched");
  a_ack_stretch: assert property (scl_oe && $past(scl_oe) |-> sda_oe)
    else $error("clock held without acknowledge");
  a_stretch_len: assert property ($fell(scl_oe)
    |-> hold_cnt_ff + 1 >= WR_DELAY_CYC && hold_cnt_ff <= WR_DELAY_CYC + 2)
    else $error("clock hold length wrong");
  a_data_steady: assert property (scl_in && $past(scl_in) && $past(scl_in, 2)
    |-> $stable(sda_oe))
    else $error("data changed while clock high");
  a_ro_slots: assert property ($stable(ctrl_reg_image[8'h2C])
    && $stable(ctrl_reg_image[8'h2D]) && $stable(ctrl_reg_image[8'h05]))
    else $error("read-only or reserved slot changed");
endmodule : vdrp_checker

bind vdrp_top vdrp_checker #(.WR_DELAY_CYC(WR_DELAY_CYC)) chk (
  .sys_clk, .rst_b, .scl_in, .scl_out, .scl_oe, .sda_out, .sda_oe,
  .slave_addr_select_pin, .power_down_pin_n, .hard_reset_pin_n,
  .ctrl_reg_image, .dec_power_down, .dec_in_reset, .addr_select_latched
);

// ### bench/vdrp_i2c_master.sv
// Behavioural serial bus master that stands on the far side of the port.
`timescale 1ns/1ns
module vdrp_i2c_master (
  // Pacing clock
  input wire logic clk,
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Drives, 1 releases the line
  output logic     scl_drv,
  output logic     sda_drv
);
  // ****************************************************************
  // Bit and byte tasks
  // ****************************************************************
  int unsigned low_cyc;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    low_cyc = 0;
  end
  task automatic gap();
    repeat (6) @(negedge clk);
  endtask : gap
  // The wait on a held clock is bounded so a stuck device shows as a hang count.
  task automatic bit_io(input logic b, output logic r);
    int n;
    sda_drv = b;
    gap();
    scl_drv = 1'b1;
    n = 0;
    @(negedge clk);
    while (scl !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    low_cyc = n;
    gap();
    r = sda;
    scl_drv = 1'b0;
    repeat (2) @(negedge clk);
  endtask : bit_io
  task automatic start();
    sda_drv = 1'b1;
    gap();
    scl_drv = 1'b1;
    gap();
    sda_drv = 1'b0;
    gap();
    scl_drv = 1'b0;
    repeat (2) @(negedge clk);
  endtask : start
  task automatic stop();
    sda_drv = 1'b0;
    gap();
    scl_drv = 1'b1;
    gap();
    sda_drv = 1'b1;
    gap();
  endtask : stop
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : put
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : get
endmodule : vdrp_i2c_master

// ### bench/tb_top.sv
// Self-checking bench for the video decoder register port.
`timescale 1ns/1ns
module tb_top;
  // ****************************************************************
  // Wiring
  // ****************************************************************
  localparam int unsigned WR_CYC = 20;
  logic sys_clk, rst_b, scl_w, sda_w, scl_drv, sda_drv, ack;
  logic scl_out, scl_oe, sda_out, sda_oe, strap, pdn_n, hrst_n;
  logic dec_power_down, dec_in_reset, addr_select_latched;
  logic [vdrp_pkg::NUM_REGS-1:0][7:0] ctrl_reg_image;
  logic [7:0] dev_w;
  logic [7:0] rd_q [0:48];
  int   errors = 0, tests_run = 0, cycles = 0;
  assign scl_w = scl_drv & ~scl_oe;
  assign sda_w = sda_drv & ~sda_oe;
  vdrp_top #(.WR_DELAY_CYC(WR_CYC)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .scl_link_clk(scl_w),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .slave_addr_select_pin(strap), .power_down_pin_n(pdn_n),
    .hard_reset_pin_n(hrst_n), .blue_diff_gain_in(8'h5C), .red_diff_gain_in(8'hA3),
    .ctrl_reg_image(ctrl_reg_image), .dec_power_down(dec_power_down),
    .dec_in_reset(dec_in_reset), .addr_select_latched(addr_select_latched)
  );
  vdrp_i2c_master mst (
    .clk(sys_clk), .scl(scl_w), .sda(sda_w), .scl_drv(scl_drv), .sda_drv(sda_drv)
  );
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      final_report();
    end
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  // The link side sees reset only on SCL edges: three idle pulses inside it, two after.
  task automatic do_reset(input logic s);
    @(negedge sys_clk);
    rst_b = 1'b0;
    strap = s;
    dev_w = s ? 8'hBA : 8'hB8;
    repeat (4) @(negedge sys_clk);
    repeat (3) mst.bit_io(1'b1, ack);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    mst.bit_io(1'b1, ack);
    mst.bit_io(1'b1, ack);
  endtask : do_reset
  task automatic wr(input logic [7:0] sub, input logic [7:0] d, input int n);
    mst.start();
    mst.put(dev_w, ack);
    check("addr ack", {7'h0, ack}, 8'h01);
    mst.put(sub, ack);
    check("sub ack", {7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      mst.put(d + 8'(i), ack);
      check("data ack", {7'h0, ack}, 8'h01);
      check("stretch", {7'h0, mst.low_cyc > 0}, {7'h0, sub + 8'(i) < 8'h90});
    end
    mst.stop();
  endtask : wr
  task automatic rd(input logic [7:0] sub, input int n);
    mst.start();
    mst.put(dev_w, ack);
    mst.put(sub, ack);
    check("sub ack", {7'h0, ack}, 8'h01);
    mst.stop();
    mst.start();
    mst.put(dev_w | 8'h01, ack);
    check("read ack", {7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) mst.get(i == n - 1, rd_q[i]);
    repeat (6) @(negedge sys_clk);
    check("release", {7'h0, sda_oe}, 8'h00);
    mst.stop();
  endtask : rd
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_defaults();
    rd(8'h00, 49);
    for (int i = 0; i < 49; i++) begin
      check("default", rd_q[i], i == 44 ? 8'h5C : i == 45 ? 8'hA3 : vdrp_pkg::REG_RST[i]);
      if (i < 44 || i > 45) check("image", ctrl_reg_image[i], vdrp_pkg::REG_RST[i]);
    end
    check("strap", {7'h0, addr_select_latched}, 8'h00);
  endtask : t_defaults
  task automatic t_writes();
    wr(8'h09, 8'h11, 3);
    wr(8'h8F, 8'h70, 2);
    wr(8'h2C, 8'h33, 2);
    wr(8'h05, 8'h44, 1);
    rd(8'h05, 1);
    check("reserved", rd_q[0], 8'h00);
    rd(8'h09, 3);
    for (int i = 0; i < 3; i++) check("rw", rd_q[i], 8'h11 + 8'(i));
    rd(8'h2C, 2);
    check("ro", rd_q[0], 8'h5C);
    check("ro", rd_q[1], 8'hA3);
    check("image", ctrl_reg_image[9], 8'h11);
  endtask : t_writes
  task automatic t_badaddr(input logic [7:0] a);
    mst.start();
    mst.put(a, ack);
    check("foreign", {7'h0, ack}, 8'h00);
    mst.put(8'h09, ack);
    check("ignored", {7'h0, ack}, 8'h00);
    mst.stop();
  endtask : t_badaddr
  task automatic t_pins();
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      {pdn_n, hrst_n} = 2'(i);
      repeat (10) @(negedge sys_clk);
      check("pdown", {7'h0, dec_power_down}, {7'h0, i == 1});
      check("inrst", {7'h0, dec_in_reset}, {7'h0, i[0] == 1'b0});
    end
    mst.bit_io(1'b1, ack);
    mst.bit_io(1'b1, ack);
    rd(8'h09, 1);
    check("pin reset", rd_q[0], 8'h80);
  endtask : t_pins
  task automatic t_strap();
    do_reset(1'b1);
    check("strap", {7'h0, addr_select_latched}, 8'h01);
    wr(8'h0C, 8'h3C, 1);
    rd(8'h0C, 1);
    check("hi pair", rd_q[0], 8'h3C);
    t_badaddr(8'hB8);
    t_badaddr(8'hB9);
  endtask : t_strap
  initial begin
    rst_b = 1'b0;
    strap = 1'b0;
    pdn_n = 1'b1;
    hrst_n = 1'b1;
    dev_w = 8'hB8;
    do_reset(1'b0);
    t_defaults();
    t_writes();
    t_badaddr(8'hBA);
    t_badaddr(8'hBB);
    t_pins();
    t_strap();
    final_report();
  end
endmodule : tb_top
